/* File: design/arf_map.svh */
// Register offsets, field positions, reset values and codes of the result framer.
`ifndef ARF_MAP_SVH
`define ARF_MAP_SVH
`define ARF_OFS_CFG0 8'h00
`define ARF_OFS_CFG1 8'h01
`define ARF_OFS_CFG2 8'h02
`define ARF_OFS_CFG3 8'h03
`define ARF_OFS_CMD 8'h04
`define ARF_OFS_RREQ 8'h05
`define ARF_OFS_STAT 8'h06
`define ARF_OFS_CNT 8'h07
`define ARF_RST_CFG0 8'h00
`define ARF_RST_CFG1 8'h00
`define ARF_RST_CFG2 8'h00
`define ARF_RST_CFG3 8'h00
`define ARF_CFG0_MUX_HI 7
`define ARF_CFG0_MUX_LO 4
`define ARF_CFG0_GAIN_HI 3
`define ARF_CFG0_GAIN_LO 1
`define ARF_CFG0_BYP 0
`define ARF_CFG1_TS 0
`define ARF_CFG1_VREF_HI 2
`define ARF_CFG1_VREF_LO 1
`define ARF_CFG1_CM 3
`define ARF_CFG2_COUNTER_PREFIX_ENABLE 6
`define ARF_CFG2_CRC_HI 5
`define ARF_CFG2_CRC_LO 4
`define ARF_CFG3_DIR_HI 6
`define ARF_CFG3_DIR_LO 4
`define ARF_CFG3_SEL 3
`define ARF_CFG3_DAT_HI 2
`define ARF_CFG3_DAT_LO 0
`define ARF_CMD_START 0
`define ARF_CMD_SLEEP 1
`define ARF_CMD_RESET 2
`define ARF_CMD_RDATA 3
`define ARF_MUX_MON_REF 4'hc
`define ARF_MUX_MON_SUP 4'hd
`define ARF_VREF_INT 2'h0
`define ARF_GAIN_ONE 3'h0
`define ARF_INT_NONE 2'h0
`define ARF_INT_INV 2'h1
`define ARF_INT_CRC 2'h2
`define ARF_CRC_POLY 16'h1021
`define ARF_CRC_INIT 16'h00ff
`define ARF_CNT_RST 8'h00
`define ARF_TEMP_PAD 10'h000
`define ARF_BAUD_DIV 16'h0683
`endif

/* File: design/arf_pkg.sv */
// Types shared by the result framer: power states and the full state record.
package arf_pkg;
  // Power and conversion states, Gray coded along low, convert, pending, down.
  typedef enum logic [1:0]
  {
    PS_LOW = 2'b00,
    PS_CONV = 2'b01,
    PS_SLPEND = 2'b11,
    PS_DOWN = 2'b10
  } arf_pstate_type;

  // Every register of the framer lives in this record.
  typedef struct packed
  {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cnt;
    logic [23:0] res;
    logic [7:0] cntcap;
    logic result_ready_indicator_n;
    arf_pstate_type pst;
    logic conv_start;
    logic [3:0][7:0] buf_b;
    logic [2:0] nbytes;
    logic [3:0] flen;
    logic [3:0] idx;
    logic [15:0] crc;
    logic [9:0] sh;
    logic [3:0] bits;
    logic [15:0] bcnt;
    logic busy;
    logic tx;
    logic [2:0] pin_out;
    logic [2:0] pin_oe_n;
    logic [2:0] pin_smp;
    logic [7:0] rdata;
    logic [3:0] mux_eff;
    logic [2:0] gain_eff;
    logic byp_eff;
    logic [1:0] vref_eff;
    logic temp_mode;
  } arf_state_type;
endpackage

/* File: design/arf_top.sv */
// Result framer: config registers, counter, integrity suffix, pins, power states.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "arf_map.svh"

// Overview of operation
// - Monitor source forces unity gain, bypass
// - Supply monitor always uses internal reference
// - Reference monitor uses internal reference
// - Temperature mode ignores config 0, internal ref
// - Temperature uses normal start and read flow
// - Temperature code sits in top 14 bits
// - Code is 0.03125 C per count, two's complement
// - Counter byte precedes result when enabled
// - Counter increments per conversion, wraps at FFh
// - Counter clears on enable re-set, reset
// - Integrity covers register reads, results, counter
// - Mode 01 sends inverted copy after MSB
// - Mode 10 sends 16-bit checksum after MSB
// - CCITT polynomial, init FFh, data bytes only
// - Each pin has own direction bit
// - Value bit reads input, drives output
// - Pin 2 select picks value or ready
// - Any reset restores defaults, low power
// - Sleep waits for running conversion to finish
// - Ready falls on result, rises when latched
// - Bytes framed start low, LSB first, stop high
module arf_top #(
  parameter logic [15:0] BAUD_DIV = `ARF_BAUD_DIV // Clock cycles per link bit.
) (
  input wire logic clk_sys, // 200 MHz system clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
  input wire logic conv_done, // One-cycle pulse: conversion finished.
  input wire logic [23:0] conv_data, // Filter result for analog inputs.
  input wire logic [13:0] temp_code, // Temperature sensor code.
  output logic conv_start, // One-cycle pulse: begin a conversion.
  output logic [3:0] mux_eff, // Effective input selection.
  output logic [2:0] gain_eff, // Effective gain code, zero is unity.
  output logic pga_bypass, // Amplifier bypass.
  output logic [1:0] vref_eff, // Effective reference selection.
  output logic temp_mode, // Temperature sensor is being measured.
  output logic powered_down, // Device sits in power-down.
  input wire logic [2:0] pin_in, // General-purpose pin levels.
  output logic [2:0] pin_out, // General-purpose pin drive levels.
  output logic [2:0] pin_oe_n, // Pin output enables, low drives.
  output logic tx_pin, // Serial transmit line, idle high.
  output logic frame_busy // A frame is being sent.
);

  // Checksum of one byte folded into a running value, MSB first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ d[i])
      begin
        r = {r[14:0], 1'b0} ^ `ARF_CRC_POLY;
      end
      else
      begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Values every register takes after any reset.
  function automatic arf_pkg::arf_state_type reset_val();
    arf_pkg::arf_state_type r;
    r = '0;
    r.cfg0 = `ARF_RST_CFG0;
    r.cfg1 = `ARF_RST_CFG1;
    r.cfg2 = `ARF_RST_CFG2;
    r.cfg3 = `ARF_RST_CFG3;
    r.cnt = `ARF_CNT_RST;
    r.result_ready_indicator_n = 1'b1;
    r.pst = arf_pkg::PS_LOW;
    r.crc = `ARF_CRC_INIT;
    r.tx = 1'b1;
    r.pin_oe_n = 3'h7;
    r.gain_eff = `ARF_GAIN_ONE;
    r.vref_eff = `ARF_VREF_INT;
    return r;
  endfunction

  arf_pkg::arf_state_type s_ff; // Registered state.
  arf_pkg::arf_state_type nxt_s; // Next state.
  logic [3:0] mux_cfg; // Configured input selection.
  logic monitor_sel; // A monitoring source is selected.
  logic [1:0] int_mode; // Integrity mode.
  logic [2:0] gp_dir; // Pin directions, one is output.
  logic [2:0] gp_dat; // Stored pin values.
  logic [7:0] cfg3_rd; // Pin register as software sees it.
  logic [7:0] rreg_val; // Register chosen for a framed readback.
  logic [7:0] rd_val; // Register chosen for a bus read.
  logic [7:0] next_byte; // Byte that the serializer loads next.

  assign mux_cfg = s_ff.cfg0[`ARF_CFG0_MUX_HI:`ARF_CFG0_MUX_LO];
  assign monitor_sel = (mux_cfg == `ARF_MUX_MON_REF) || (mux_cfg == `ARF_MUX_MON_SUP);
  assign int_mode = s_ff.cfg2[`ARF_CFG2_CRC_HI:`ARF_CFG2_CRC_LO];
  assign gp_dir = s_ff.cfg3[`ARF_CFG3_DIR_HI:`ARF_CFG3_DIR_LO];
  assign gp_dat = s_ff.cfg3[`ARF_CFG3_DAT_HI:`ARF_CFG3_DAT_LO];

  // Inputs return the sampled level, outputs the stored value.
  always_comb
  begin
    cfg3_rd = s_ff.cfg3;
    cfg3_rd[`ARF_CFG3_DAT_HI:`ARF_CFG3_DAT_LO] = (gp_dat & gp_dir) | (s_ff.pin_smp & ~gp_dir);
  end

  // Register decode: bus reads by address, framed readback by write data bits 1:0.
  always_comb
  begin
    case (reg_addr)
      `ARF_OFS_CFG0: rd_val = s_ff.cfg0;
      `ARF_OFS_CFG1: rd_val = s_ff.cfg1;
      `ARF_OFS_CFG2: rd_val = s_ff.cfg2;
      `ARF_OFS_CFG3: rd_val = cfg3_rd;
      `ARF_OFS_STAT: rd_val = {3'h0, s_ff.busy, s_ff.result_ready_indicator_n, 1'b0, s_ff.pst};
      `ARF_OFS_CNT: rd_val = s_ff.cnt;
      default: rd_val = 8'h00;
    endcase
    case (reg_wdata[1:0])
      2'h0: rreg_val = s_ff.cfg0;
      2'h1: rreg_val = s_ff.cfg1;
      2'h2: rreg_val = s_ff.cfg2;
      default: rreg_val = cfg3_rd;
    endcase
  end

  // Data bytes first, then the inverted copy or the checksum after the MSB.
  always_comb
  begin
    if (s_ff.idx < s_ff.nbytes)
    begin
      next_byte = s_ff.buf_b[s_ff.idx];
    end
    else if (int_mode == `ARF_INT_INV)
    begin
      next_byte = ~s_ff.buf_b[s_ff.idx - s_ff.nbytes];
    end
    else if (s_ff.idx == s_ff.nbytes)
    begin
      next_byte = s_ff.crc[15:8];
    end
    else
    begin
      next_byte = s_ff.crc[7:0];
    end
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.conv_start = 1'b0;
    nxt_s.rdata = 8'h00;
    nxt_s.pin_smp = pin_in;
    if (reg_rd)
    begin
      nxt_s.rdata = rd_val;
    end
    // Conversion completion: count, capture result and counter together.
    if (conv_done && (s_ff.pst != arf_pkg::PS_LOW) && (s_ff.pst != arf_pkg::PS_DOWN))
    begin
      nxt_s.cnt = s_ff.cnt + 8'h01;
      nxt_s.cntcap = s_ff.cnt + 8'h01;
      if (s_ff.cfg1[`ARF_CFG1_TS])
      begin
        nxt_s.res = {temp_code, `ARF_TEMP_PAD};
      end
      else
      begin
        nxt_s.res = conv_data;
      end
      if (s_ff.pst == arf_pkg::PS_SLPEND)
      begin
        nxt_s.pst = arf_pkg::PS_DOWN;
      end
      else if (!s_ff.cfg1[`ARF_CFG1_CM])
      begin
        nxt_s.pst = arf_pkg::PS_LOW;
      end
    end
    // Configuration writes; re-enabling the counter clears it.
    if (reg_wr)
    begin
      case (reg_addr)
        `ARF_OFS_CFG0: nxt_s.cfg0 = reg_wdata;
        `ARF_OFS_CFG1: nxt_s.cfg1 = reg_wdata;
        `ARF_OFS_CFG3: nxt_s.cfg3 = reg_wdata;
        `ARF_OFS_CFG2:
        begin
          nxt_s.cfg2 = reg_wdata;
          if (reg_wdata[`ARF_CFG2_COUNTER_PREFIX_ENABLE] && !s_ff.cfg2[`ARF_CFG2_COUNTER_PREFIX_ENABLE])
          begin
            nxt_s.cnt = `ARF_CNT_RST;
          end
        end
        `ARF_OFS_CMD:
        begin
          if (reg_wdata[`ARF_CMD_START])
          begin
            nxt_s.pst = arf_pkg::PS_CONV;
            nxt_s.conv_start = 1'b1;
          end
          else if (reg_wdata[`ARF_CMD_SLEEP])
          begin
            // A running conversion is allowed to finish first.
            nxt_s.pst = (s_ff.pst == arf_pkg::PS_CONV || s_ff.pst == arf_pkg::PS_SLPEND) ?
                        arf_pkg::PS_SLPEND : arf_pkg::PS_DOWN;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Ready falls on every new result; a new result beats a same-cycle latch.
    if (conv_done && (s_ff.pst != arf_pkg::PS_LOW) && (s_ff.pst != arf_pkg::PS_DOWN))
    begin
      nxt_s.result_ready_indicator_n = 1'b0;
    end
    // Frame start: result read or register readback, ignored while busy.
    if (!s_ff.busy && reg_wr &&
        (reg_addr == `ARF_OFS_RREQ || (reg_addr == `ARF_OFS_CMD && reg_wdata[`ARF_CMD_RDATA])))
    begin
      nxt_s.busy = 1'b1;
      nxt_s.idx = 4'h0;
      nxt_s.bits = 4'h0;
      nxt_s.bcnt = 16'h0000;
      nxt_s.crc = `ARF_CRC_INIT;
      if (reg_addr == `ARF_OFS_RREQ)
      begin
        nxt_s.buf_b = {24'h00_0000, rreg_val};
        nxt_s.nbytes = 3'h1;
      end
      else
      begin
        if (!conv_done)
        begin
          nxt_s.result_ready_indicator_n = 1'b1;
        end
        if (s_ff.cfg2[`ARF_CFG2_COUNTER_PREFIX_ENABLE])
        begin
          nxt_s.buf_b = {s_ff.res[23:16], s_ff.res[15:8], s_ff.res[7:0], s_ff.cntcap};
          nxt_s.nbytes = 3'h4;
        end
        else
        begin
          nxt_s.buf_b = {8'h00, s_ff.res[23:16], s_ff.res[15:8], s_ff.res[7:0]};
          nxt_s.nbytes = 3'h3;
        end
      end
    end
    // Frame length follows the integrity mode.
    if (nxt_s.busy && !s_ff.busy)
    begin
      case (int_mode)
        // Counter plus inverted copy needs eight bytes, so the length is four bits wide.
        `ARF_INT_INV: nxt_s.flen = {nxt_s.nbytes, 1'b0};
        `ARF_INT_CRC: nxt_s.flen = {1'b0, nxt_s.nbytes} + 4'h2;
        default: nxt_s.flen = {1'b0, nxt_s.nbytes};
      endcase
    end
    // Serializer: one start bit, eight data bits LSB first, one stop bit.
    if (s_ff.busy)
    begin
      if (s_ff.bcnt != 16'h0000)
      begin
        nxt_s.bcnt = s_ff.bcnt - 16'h0001;
      end
      else if (s_ff.bits != 4'h0)
      begin
        nxt_s.tx = s_ff.sh[0];
        nxt_s.sh = {1'b1, s_ff.sh[9:1]};
        nxt_s.bits = s_ff.bits - 4'h1;
        nxt_s.bcnt = BAUD_DIV - 16'h0001;
      end
      else if (s_ff.idx < s_ff.flen)
      begin
        nxt_s.sh = {1'b1, next_byte, 1'b0};
        nxt_s.bits = 4'ha;
        nxt_s.idx = s_ff.idx + 4'h1;
        if (s_ff.idx < s_ff.nbytes)
        begin
          nxt_s.crc = crc_byte(s_ff.crc, next_byte);
        end
      end
      else
      begin
        nxt_s.busy = 1'b0;
        nxt_s.tx = 1'b1;
      end
    end
    // The reset command wins over everything else in the same cycle.
    if (reg_wr && reg_addr == `ARF_OFS_CMD && reg_wdata[`ARF_CMD_RESET])
    begin
      nxt_s = reset_val();
      nxt_s.pin_smp = pin_in;
    end
    // Effective front-end settings from the next configuration.
    nxt_s.mux_eff = nxt_s.cfg0[`ARF_CFG0_MUX_HI:`ARF_CFG0_MUX_LO];
    nxt_s.gain_eff = nxt_s.cfg0[`ARF_CFG0_GAIN_HI:`ARF_CFG0_GAIN_LO];
    nxt_s.byp_eff = nxt_s.cfg0[`ARF_CFG0_BYP];
    nxt_s.vref_eff = nxt_s.cfg1[`ARF_CFG1_VREF_HI:`ARF_CFG1_VREF_LO];
    nxt_s.temp_mode = nxt_s.cfg1[`ARF_CFG1_TS];
    if (nxt_s.mux_eff == `ARF_MUX_MON_REF || nxt_s.mux_eff == `ARF_MUX_MON_SUP)
    begin
      nxt_s.gain_eff = `ARF_GAIN_ONE;
      nxt_s.byp_eff = 1'b1;
      nxt_s.vref_eff = `ARF_VREF_INT;
    end
    if (nxt_s.temp_mode)
    begin
      nxt_s.mux_eff = 4'(`ARF_RST_CFG0 >> `ARF_CFG0_MUX_LO);
      nxt_s.gain_eff = `ARF_GAIN_ONE;
      nxt_s.byp_eff = 1'b0;
      nxt_s.vref_eff = `ARF_VREF_INT;
    end
    // Pin drivers; pin 2 may carry the ready indicator instead.
    nxt_s.pin_oe_n = ~nxt_s.cfg3[`ARF_CFG3_DIR_HI:`ARF_CFG3_DIR_LO];
    nxt_s.pin_out = nxt_s.cfg3[`ARF_CFG3_DAT_HI:`ARF_CFG3_DAT_LO];
    if (nxt_s.cfg3[`ARF_CFG3_SEL])
    begin
      nxt_s.pin_out[2] = nxt_s.result_ready_indicator_n;
    end
  end

  // State register; asynchronous reset loads the same defaults as the command.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= reset_val();
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata = s_ff.rdata;
  assign conv_start = s_ff.conv_start;
  assign mux_eff = s_ff.mux_eff;
  assign gain_eff = s_ff.gain_eff;
  assign pga_bypass = s_ff.byp_eff;
  assign vref_eff = s_ff.vref_eff;
  assign temp_mode = s_ff.temp_mode;
  assign powered_down = (s_ff.pst == arf_pkg::PS_DOWN);
  assign pin_out = s_ff.pin_out;
  assign pin_oe_n = s_ff.pin_oe_n;
  assign tx_pin = s_ff.tx;
  assign frame_busy = s_ff.busy;

  logic done_live; // Completion that the block accepts.
  assign done_live = conv_done && (s_ff.pst == arf_pkg::PS_CONV || s_ff.pst == arf_pkg::PS_SLPEND);

  property p_mon_unity;
    @(posedge clk_sys) disable iff (rst)
    (monitor_sel && !s_ff.cfg1[`ARF_CFG1_TS] && !reg_wr) |=>
      (gain_eff == `ARF_GAIN_ONE && pga_bypass && vref_eff == `ARF_VREF_INT);
  endproperty
  a_mon_unity: assert property (p_mon_unity) else $error("monitor not at unity gain");

  property p_temp_ignore;
    @(posedge clk_sys) disable iff (rst)
    (s_ff.cfg1[`ARF_CFG1_TS] && !reg_wr) |=> (vref_eff == `ARF_VREF_INT && !pga_bypass);
  endproperty
  a_temp_ignore: assert property (p_temp_ignore) else $error("temperature mode uses config");

  property p_cnt_inc;
    @(posedge clk_sys) disable iff (rst)
    (done_live && !reg_wr) |=> (s_ff.cnt == $past(s_ff.cnt) + 8'h01 && s_ff.cntcap == s_ff.cnt);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not advance");

  property p_cnt_clr;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == `ARF_OFS_CFG2 && reg_wdata[`ARF_CFG2_COUNTER_PREFIX_ENABLE] &&
     !s_ff.cfg2[`ARF_CFG2_COUNTER_PREFIX_ENABLE]) |=> (s_ff.cnt == `ARF_CNT_RST);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");

  property p_ready_fall;
    @(posedge clk_sys) disable iff (rst)
    done_live && !(reg_wr && reg_addr == `ARF_OFS_CMD) |=> !s_ff.result_ready_indicator_n;
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall");

  sequence s_load;
    s_ff.busy && s_ff.bcnt == 16'h0000 && s_ff.bits == 4'h0 && s_ff.idx < s_ff.flen;
  endsequence
  sequence s_start_bit;
    ##1 (s_ff.bits == 4'ha) ##1 !tx_pin;
  endsequence
  property p_start_low;
    @(posedge clk_sys) disable iff (rst)
    (s_load and !(reg_wr && reg_addr == `ARF_OFS_CMD)) |-> s_start_bit;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_sleep_wait;
    @(posedge clk_sys) disable iff (rst)
    (s_ff.pst == arf_pkg::PS_SLPEND && !conv_done && !reg_wr) |=> !powered_down;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("powered down early");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == `ARF_OFS_CMD && reg_wdata[`ARF_CMD_RESET]) |=>
      (s_ff.pst == arf_pkg::PS_LOW && s_ff.cfg2 == `ARF_RST_CFG2 && s_ff.cnt == `ARF_CNT_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset left state");

  property p_pin2_ready;
    @(posedge clk_sys) disable iff (rst)
    (s_ff.cfg3[`ARF_CFG3_SEL] && !reg_wr && !conv_done && !s_ff.busy) |=>
      (pin_out[2] == s_ff.result_ready_indicator_n);
  endproperty
  a_pin2_ready: assert property (p_pin2_ready) else $error("pin 2 not ready level");

endmodule

/* File: verif/arf_host_model.sv */
// Host-side serial receiver model that collects the bytes the framer sends.
`timescale 1ns/1ps
module arf_host_model #(
  parameter int BAUD = 4 // Clock cycles per link bit.
) (
  input wire logic clk_sys, // System clock shared with the framer.
  input wire logic rst, // Reset, active high.
  input wire logic tx_pin, // Serial line from the framer.
  output logic [7:0] rx_byte, // Last byte received.
  output logic rx_stb, // One-cycle pulse per received byte.
  output logic rx_ferr // High when the stop bit of the last byte was not high.
);
  // Bits are sampled near their middle. The line is read at the clock edge, before the
  // framer's updates of that edge land, so a sample never races the driver.
  initial
  begin
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    rx_ferr = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      rx_stb <= 1'b0;
      // A low line while idle is taken as the start bit.
      if (rst === 1'b0 && tx_pin === 1'b0)
      begin
        repeat (BAUD / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BAUD) @(posedge clk_sys);
          rx_byte[i] <= tx_pin;
        end
        repeat (BAUD) @(posedge clk_sys);
        rx_ferr <= (tx_pin !== 1'b1);
        rx_stb <= 1'b1;
      end
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the result framer, with a serial host model on its line.
`timescale 1ns/1ps
`include "arf_map.svh"
module tb_top;
  typedef logic [7:0] arf_bq_type[$]; // Bytes of one frame.
  logic clk_sys; // System clock.
  logic rst; // Reset, active high.
  logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register bus.
  logic reg_wr, reg_rd; // Register strobes.
  logic conv_done, conv_start; // Conversion handshake.
  logic [23:0] conv_data; // Analog result fed in.
  logic [13:0] temp_code; // Temperature code fed in.
  logic [3:0] mux_eff; // Effective input selection.
  logic [2:0] gain_eff; // Effective gain.
  logic pga_bypass, temp_mode, powered_down; // Path and power status.
  logic [1:0] vref_eff; // Effective reference.
  logic [2:0] pin_in, pin_out, pin_oe_n; // General-purpose pins.
  logic tx_pin, frame_busy; // Serial line and frame status.
  logic [7:0] rx_byte; // Byte from the host model.
  logic rx_stb, rx_ferr; // Host model strobes.
  int seed, miscompares, compares, nstart, n0; // Seed and counters.
  logic [7:0] v, v2, exp_cnt; // Read data and expected counter.
  logic [23:0] d, dd; // Random and expected results.
  logic [13:0] t; // Random temperature code.
  logic [1:0] md; // Integrity mode of a pass.
  arf_bq_type got, q; // Received and expected bytes.

  arf_top #(.BAUD_DIV(16'h0004)) arf_top_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_data(conv_data), .temp_code(temp_code), .conv_start(conv_start),
    .mux_eff(mux_eff), .gain_eff(gain_eff), .pga_bypass(pga_bypass),
    .vref_eff(vref_eff), .temp_mode(temp_mode), .powered_down(powered_down),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .tx_pin(tx_pin),
    .frame_busy(frame_busy)
  );
  arf_host_model #(.BAUD(4)) arf_host_model_i (
    .clk_sys(clk_sys), .rst(rst), .tx_pin(tx_pin), .rx_byte(rx_byte),
    .rx_stb(rx_stb), .rx_ferr(rx_ferr)
  );

  // Free-running 200 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] seen);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One-cycle register write; the strobe is sampled at the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= dv;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; the data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    dv = reg_rdata;
  endtask

  task automatic done_pulse(input logic [23:0] dv, input logic [13:0] tv);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_data <= dv;
    temp_code <= tv;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Appends the integrity suffix: inverted copies, or the checksum taken MSB first.
  function automatic arf_bq_type add_check(input arf_bq_type b, input logic [1:0] mode);
    arf_bq_type r;
    logic [15:0] c;
    logic fb;
    r = b;
    c = 16'h00ff;
    foreach (b[i])
    begin
      if (mode == `ARF_INT_INV)
        r.push_back(~b[i]);
      for (int k = 7; k >= 0; k--)
      begin
        fb = c[15] ^ b[i][k];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    if (mode == `ARF_INT_CRC)
    begin
      r.push_back(c[15:8]);
      r.push_back(c[7:0]);
    end
    return r;
  endfunction

  // Expected {mux, gain, bypass, reference, temperature} for given settings.
  function automatic logic [10:0] exp_path(input logic [7:0] c0, input logic [7:0] c1);
    if (c1[0])
      return 11'h001;
    if (c0[7:4] == `ARF_MUX_MON_REF || c0[7:4] == `ARF_MUX_MON_SUP)
      return {c0[7:4], 3'h0, 1'b1, 2'h0, 1'b0};
    return {c0, c1[2:1], 1'b0};
  endfunction

  // Requests a frame and compares the bytes that the host model collects.
  task automatic frame(input logic [7:0] a, input logic [7:0] dv, input arf_bq_type exp);
    int n;
    got.delete();
    wr(a, dv);
    n = 0;
    while (frame_busy !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (frame_busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    chk("frame_len", 24'(exp.size()), 24'(got.size()));
    foreach (exp[i])
      if (i < got.size())
        chk("frame_byte", exp[i], got[i]);
  endtask

  task automatic defaults_ok;
    for (int a = 0; a < 4; a++)
    begin
      rd(8'(a), v);
      chk("cfg_default", 24'h0, v);
    end
    rd(`ARF_OFS_CNT, v);
    chk("count_default", 24'h0, v);
    chk("pins_default", 24'h07, {powered_down, pin_oe_n});
  endtask

  // Collects received bytes; a stop bit that is not high is a fault.
  always @(posedge clk_sys)
  begin
    if (rx_stb === 1'b1)
    begin
      got.push_back(rx_byte);
      chk("stop_bit", 24'h0, rx_ferr);
    end
    if (conv_start === 1'b1)
      nstart++;
  end

  // Cuts a hang short; the whole run needs well under this many cycles.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    seed = 40000;
    {reg_addr, reg_wdata, reg_wr, reg_rd, conv_done, conv_data, temp_code, pin_in} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    defaults_ok();
    rd(8'h0f, v);
    chk("unmapped_read", 24'h0, v);
    // Monitor, plain and temperature paths.
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      d[7:0] = (i == 0) ? {`ARF_MUX_MON_SUP, v[3:0]} :
               (i == 1) ? {`ARF_MUX_MON_REF, v[3:0]} : {v[7:4] & 4'hb, v[3:0]};
      d[15:8] = {5'h00, v[5:4], i >= 4};
      wr(`ARF_OFS_CFG0, d[7:0]);
      wr(`ARF_OFS_CFG1, d[15:8]);
      repeat (2) @(posedge clk_sys);
      chk("path", exp_path(d[7:0], d[15:8]),
          {mux_eff, gain_eff, pga_bypass, vref_eff, temp_mode});
    end
    // Single conversions read back under every integrity mode.
    for (int i = 0; i < 6; i++)
    begin
      md = 2'(i % 3);
      wr(`ARF_OFS_CFG1, {7'h00, i[0]});
      if (i == 3)
      begin
        wr(`ARF_OFS_CFG2, 8'h00);
        exp_cnt = 8'h00;
      end
      wr(`ARF_OFS_CFG2, {1'b0, i >= 3, md, 4'h0});
      d = 24'($random(seed));
      t = (i == 1) ? 14'h3ce0 : 14'($random(seed));
      n0 = nstart;
      wr(`ARF_OFS_CMD, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk("start_pulses", 24'(n0 + 1), 24'(nstart));
      done_pulse(d, t);
      exp_cnt++;
      rd(`ARF_OFS_STAT, v);
      chk("ready_low", 24'h0, v[3]);
      dd = i[0] ? {t, 10'h000} : d;
      q.delete();
      if (i >= 3)
        q.push_back(exp_cnt);
      q.push_back(dd[7:0]);
      q.push_back(dd[15:8]);
      q.push_back(dd[23:16]);
      frame(`ARF_OFS_CMD, 8'h08, add_check(q, md));
      rd(`ARF_OFS_STAT, v);
      chk("ready_high", 24'h1, v[3]);
    end
    // Register readback frames carry the same suffix.
    wr(`ARF_OFS_CFG0, 8'h5a);
    for (int j = 1; j < 3; j++)
    begin
      wr(`ARF_OFS_CFG2, {2'h0, 2'(j), 4'h0});
      q.delete();
      q.push_back(8'h5a);
      frame(`ARF_OFS_RREQ, 8'h00, add_check(q, 2'(j)));
    end
    // Continuous conversions: counter wraps, sleep waits for the running one.
    wr(`ARF_OFS_CFG2, 8'h40);
    wr(`ARF_OFS_CFG1, 8'h08);
    wr(`ARF_OFS_CMD, 8'h01);
    for (int k = 0; k < 257; k++)
      done_pulse(24'($random(seed)), t);
    rd(`ARF_OFS_CNT, v);
    chk("count_wrap", 24'h01, v);
    wr(`ARF_OFS_CMD, 8'h02);
    rd(`ARF_OFS_STAT, v);
    chk("sleep_wait", 24'h3, {powered_down, v[1:0]});
    done_pulse(d, t);
    chk("sleep_entered", 24'h1, powered_down);
    wr(`ARF_OFS_CMD, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("woken", 24'h0, powered_down);
    wr(`ARF_OFS_CFG2, 8'h00);
    wr(`ARF_OFS_CFG2, 8'h40);
    rd(`ARF_OFS_CNT, v);
    chk("count_clear", 24'h0, v);
    // Pins with random directions, values and input levels.
    for (int k = 0; k < 4; k++)
    begin
      d = 24'($random(seed));
      @(posedge clk_sys);
      pin_in <= d[10:8];
      wr(`ARF_OFS_CFG3, {1'b0, d[6:4], 1'b0, d[2:0]});
      repeat (2) @(posedge clk_sys);
      chk("pin_enables", {~d[6:4]}, pin_oe_n);
      chk("pin_drive", d[2:0] & d[6:4], pin_out & d[6:4]);
      rd(`ARF_OFS_CFG3, v2);
      chk("pin_read", d[10:8] & ~d[6:4], v2[2:0] & ~d[6:4]);
    end
    // Pin 2 shows the ready level when selected, its value bit otherwise.
    wr(`ARF_OFS_CFG3, 8'h4c);
    done_pulse(d, t);
    chk("pin2_ready", 24'h0, {pin_oe_n[2], pin_out[2]});
    wr(`ARF_OFS_CFG3, 8'h44);
    repeat (2) @(posedge clk_sys);
    chk("pin2_value", 24'h1, pin_out[2]);
    // Reset by command restores every default.
    @(posedge clk_sys);
    pin_in <= 3'h0;
    wr(`ARF_OFS_CFG0, 8'ha5);
    wr(`ARF_OFS_CMD, 8'h04);
    repeat (2) @(posedge clk_sys);
    defaults_ok();
    wrap_up();
  end
endmodule
